// *** src/bbu_top.sv ***
`timescale 1ns/1ps
module bbu_top
	import bbu_pkg::*;
#(
	parameter int N_BEAMS = BBU_BEAMS
)
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	input  wire logic [N_BEAMS-1:0]   i_beams,
	input  wire logic                 i_par_wr,
	input  wire logic                 i_par_rd,
	input  wire logic [15:0]          i_par_index,
	input  wire logic [7:0]           i_par_subindex,
	input  wire logic [BBU_REC_W-1:0] i_par_wdata,
	input  wire logic                 i_teach_panel,
	input  wire logic                 i_teach_cmd,
	output logic [N_BEAMS-1:0]        o_beams,
	output logic [BBU_REC_W-1:0]      o_par_rdata,
	output logic                      o_par_ack,
	output logic                      o_par_err,
	output logic                      o_teach_busy,
	output logic                      o_teach_done
);

	logic [7:0]           cnt_q, cnt_d;
	logic [7:0]           auto_q, auto_d;
	bbu_word_arr_t        sel_q, sel_d;
	bbu_word_arr_t        first_q, first_d;
	bbu_word_arr_t        last_q, last_d;
	logic [BBU_REC_W-1:0] rdata_q, rdata_d;
	logic                 ack_q, ack_d;
	logic                 err_q, err_d;
	logic                 busy_q, busy_d;
	logic                 start_q, start_d;
	logic                 tdone_q, tdone_d;
	logic [N_BEAMS-1:0]   beams_q, beams_d;
	logic [BBU_REC_W-1:0] rec_now;
	logic                 scan_done;
	logic [2:0]           scan_cnt;
	bbu_word_arr_t        scan_first;
	bbu_word_arr_t        scan_last;
	logic [BBU_AREAS-1:0] lo_nb;
	logic [BBU_AREAS-1:0] hi_nb;
	logic [15:0]          bn;
	logic [15:0]          teach_age_q, teach_age_d;

	////////////////////////////////////////////////////////////////////////

	// Teach scan engine
	bbu_teach_scan #(
		.N_BEAMS (N_BEAMS)
	) u_scan (
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_start     (start_q),
		.i_beams     (i_beams),
		.i_max_areas ((auto_q == BBU_AUTO_ON) ? cnt_q[2:0] : 3'h0),
		.o_done      (scan_done),
		.o_area_cnt  (scan_cnt),
		.o_first     (scan_first),
		.o_last      (scan_last)
	);

	////////////////////////////////////////////////////////////////////////

	// Record image for reads
	always_comb
	begin
		rec_now = '0;
		rec_now[BBU_OFS_CNT +: 8]  = cnt_q;
		rec_now[BBU_OFS_AUTO +: 8] = auto_q;
		for (int a = 0; a < BBU_AREAS; a++)
		begin
			rec_now[BBU_OFS_SEL0 - a*BBU_STRIDE +: 16]   = sel_q[a];
			rec_now[BBU_OFS_FIRST0 - a*BBU_STRIDE +: 16] = first_q[a];
			rec_now[BBU_OFS_LAST0 - a*BBU_STRIDE +: 16]  = last_q[a];
		end
	end

	// Parameter access and teach control
	always_comb
	begin
		cnt_d   = cnt_q;
		auto_d  = auto_q;
		sel_d   = sel_q;
		first_d = first_q;
		last_d  = last_q;
		rdata_d = rdata_q;
		ack_d   = 1'b0;
		err_d   = 1'b0;
		busy_d  = busy_q;
		start_d = 1'b0;
		tdone_d = 1'b0;
		teach_age_d = busy_q ? (teach_age_q + 16'h0001) : 16'h0000;
		if (i_par_wr || i_par_rd)
		begin
			if ((i_par_index != BBU_REC_INDEX) || (i_par_subindex != 8'h00))
				err_d = 1'b1;
			else if (i_par_rd)
			begin
				rdata_d = rec_now;
				ack_d   = 1'b1;
			end
			else if (busy_q || !bbu_rec_ok(i_par_wdata))
				err_d = 1'b1;
			else
			begin
				ack_d  = 1'b1;
				cnt_d  = i_par_wdata[BBU_OFS_CNT +: 8];
				auto_d = i_par_wdata[BBU_OFS_AUTO +: 8];
				for (int a = 0; a < BBU_AREAS; a++)
				begin
					sel_d[a]   = i_par_wdata[BBU_OFS_SEL0 - a*BBU_STRIDE +: 16];
					first_d[a] = i_par_wdata[BBU_OFS_FIRST0 - a*BBU_STRIDE +: 16];
					last_d[a]  = i_par_wdata[BBU_OFS_LAST0 - a*BBU_STRIDE +: 16];
				end
			end
		end
		if (!busy_q && (i_teach_panel || i_teach_cmd))
		begin
			busy_d  = 1'b1;
			start_d = 1'b1;
		end
		if (busy_q && scan_done)
		begin
			busy_d  = 1'b0;
			tdone_d = 1'b1;
			if (auto_q == BBU_AUTO_ON)
			begin
				for (int a = 0; a < BBU_AREAS; a++)
				begin
					sel_d[a]   = (3'(a) < scan_cnt) ? BBU_SEL_ZERO : BBU_SEL_OFF;
					first_d[a] = scan_first[a];
					last_d[a]  = scan_last[a];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	// Neighbour beams just outside each area
	always_comb
	begin
		for (int a = 0; a < BBU_AREAS; a++)
		begin
			lo_nb[a] = 1'b0;
			hi_nb[a] = 1'b0;
			if ((first_q[a] >= 16'h0002) && (int'(first_q[a]) <= N_BEAMS + 1))
				lo_nb[a] = i_beams[int'(first_q[a]) - 2];
			if (int'(last_q[a]) < N_BEAMS)
				hi_nb[a] = i_beams[int'(last_q[a])];
		end
	end

	// Substitution; the lowest numbered area wins on overlap
	always_comb
	begin
		beams_d = i_beams;
		bn      = 16'h0000;
		for (int b = 0; b < N_BEAMS; b++)
		begin
			bn = 16'(b + 1);
			for (int a = BBU_AREAS - 1; a >= 0; a--)
			begin
				if ((sel_q[a] != BBU_SEL_OFF) && (bn >= first_q[a]) &&
					(bn <= last_q[a]))
				begin
					case (sel_q[a])
						BBU_SEL_ZERO:   beams_d[b] = 1'b0;
						BBU_SEL_ONE:    beams_d[b] = 1'b1;
						BBU_SEL_LOWER:  beams_d[b] = lo_nb[a];
						BBU_SEL_HIGHER: beams_d[b] = hi_nb[a];
						default:        beams_d[b] = i_beams[b];
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			cnt_q   <= BBU_CNT_RST;
			auto_q  <= BBU_AUTO_RST;
			sel_q   <= {BBU_AREAS{BBU_SEL_RST}};
			first_q <= {BBU_AREAS{BBU_BEAM_RST}};
			last_q  <= {BBU_AREAS{BBU_BEAM_RST}};
			rdata_q <= '0;
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			busy_q  <= 1'b0;
			start_q <= 1'b0;
			tdone_q <= 1'b0;
			beams_q <= '0;
			teach_age_q <= 16'h0000;
		end
		else
		begin
			cnt_q   <= cnt_d;
			auto_q  <= auto_d;
			sel_q   <= sel_d;
			first_q <= first_d;
			last_q  <= last_d;
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
			err_q   <= err_d;
			busy_q  <= busy_d;
			start_q <= start_d;
			tdone_q <= tdone_d;
			beams_q <= beams_d;
			teach_age_q <= teach_age_d;
		end
	end

	assign o_beams      = beams_q;
	assign o_par_rdata  = rdata_q;
	assign o_par_ack    = ack_q;
	assign o_par_err    = err_q;
	assign o_teach_busy = busy_q;
	assign o_teach_done = tdone_q;

	////////////////////////////////////////////////////////////////////////

	a_sub_access_err: assert property (@(posedge i_core_clk) disable iff (i_rst)
		((i_par_wr || i_par_rd) && (i_par_subindex != 8'h00)) |=>
		(o_par_err && !o_par_ack))
		else $error("sub-index access not rejected");

	a_range_reject: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_par_wr && !i_par_rd && !busy_q &&
		!bbu_rec_ok(i_par_wdata)) |=>
		(o_par_err && $stable(first_q) && $stable(last_q)))
		else $error("out of range record accepted");

	a_off_pass: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(sel_q == {BBU_AREAS{BBU_SEL_OFF}}) |=> (o_beams == $past(i_beams)))
		else $error("beams altered with all areas off");

	a_force_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
		((sel_q[0] == BBU_SEL_ZERO) && (first_q[0] <= last_q[0]) &&
		(int'(first_q[0]) <= N_BEAMS)) |=>
		!o_beams[int'($past(first_q[0])) - 1])
		else $error("blanked beam not forced to zero");

	a_force_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
		((sel_q[0] == BBU_SEL_ONE) && (first_q[0] <= last_q[0]) &&
		(int'(last_q[0]) <= N_BEAMS)) |=>
		o_beams[int'($past(last_q[0])) - 1])
		else $error("blanked beam not forced to one");

	a_lower_copy: assert property (@(posedge i_core_clk) disable iff (i_rst)
		((sel_q[0] == BBU_SEL_LOWER) && (first_q[0] >= 16'h0002) &&
		(first_q[0] <= last_q[0]) && (int'(first_q[0]) <= N_BEAMS)) |=>
		(o_beams[int'($past(first_q[0])) - 1] ==
		$past(i_beams[int'(first_q[0]) - 2])))
		else $error("lower neighbour not copied");

	a_manual_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(busy_q && scan_done && (auto_q != BBU_AUTO_ON) && !ack_d) |=>
		($stable(sel_q) && $stable(first_q) && o_teach_done))
		else $error("manual limits changed by teach");

	a_auto_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(busy_q && scan_done && (auto_q == BBU_AUTO_ON) &&
		(cnt_q == 8'h00)) |=> (sel_q == {BBU_AREAS{BBU_SEL_OFF}}))
		else $error("auto teach made areas beyond count");

	a_teach_start: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!busy_q && (i_teach_panel || i_teach_cmd)) |=>
		o_teach_busy)
		else $error("teach request not served");

	a_teach_bound: assert property (@(posedge i_core_clk) disable iff (i_rst)
		busy_q |-> (int'(teach_age_q) <= N_BEAMS + 1))
		else $error("teach ran longer than one scan");

endmodule // bbu_top

// *** src/bbu_pkg.sv ***
package bbu_pkg;

	localparam logic [15:0] BBU_REC_INDEX   = 16'h004c;
	localparam int          BBU_REC_W       = 208;
	localparam int          BBU_AREAS       = 4;
	localparam int          BBU_BEAMS       = 1774;
	localparam logic [15:0] BBU_BEAM_MIN    = 16'h0001;
	localparam logic [15:0] BBU_BEAM_MAX    = 16'h06ee;
	localparam logic [15:0] BBU_SEL_MAX     = 16'h0004;
	localparam logic [7:0]  BBU_CNT_MAX     = 8'h04;
	localparam logic [7:0]  BBU_AUTO_MAX    = 8'h01;
	localparam int          BBU_OFS_CNT     = 200;
	localparam int          BBU_OFS_AUTO    = 192;
	localparam int          BBU_OFS_SEL0    = 176;
	localparam int          BBU_OFS_FIRST0  = 160;
	localparam int          BBU_OFS_LAST0   = 144;
	localparam int          BBU_STRIDE      = 48;
	localparam logic [15:0] BBU_SEL_RST     = 16'h0000;
	localparam logic [15:0] BBU_BEAM_RST    = 16'h0001;
	localparam logic [7:0]  BBU_CNT_RST     = 8'h00;
	localparam logic [7:0]  BBU_AUTO_RST    = 8'h00;
	localparam logic [7:0]  BBU_AUTO_ON     = 8'h01;
	localparam logic [15:0] BBU_SEL_OFF     = 16'h0000;
	localparam logic [15:0] BBU_SEL_ZERO    = 16'h0001;
	localparam logic [15:0] BBU_SEL_ONE     = 16'h0002;
	localparam logic [15:0] BBU_SEL_LOWER   = 16'h0003;
	localparam logic [15:0] BBU_SEL_HIGHER  = 16'h0004;

	typedef logic [BBU_AREAS-1:0][15:0] bbu_word_arr_t;

	////////////////////////////////////////////////////////////////////////

	// Beam number inside the legal range
	function automatic logic bbu_beam_ok(input logic [15:0] v);
		bbu_beam_ok = (v >= BBU_BEAM_MIN) && (v <= BBU_BEAM_MAX);
	endfunction

	// Whole record inside its value ranges
	function automatic logic bbu_rec_ok(input logic [BBU_REC_W-1:0] r);
		logic ok;
		ok = (r[BBU_OFS_CNT +: 8] <= BBU_CNT_MAX) &&
			(r[BBU_OFS_AUTO +: 8] <= BBU_AUTO_MAX);
		for (int a = 0; a < BBU_AREAS; a++)
		begin
			ok = ok && (r[BBU_OFS_SEL0 - a*BBU_STRIDE +: 16] <= BBU_SEL_MAX)
				&& bbu_beam_ok(r[BBU_OFS_FIRST0 - a*BBU_STRIDE +: 16])
				&& bbu_beam_ok(r[BBU_OFS_LAST0 - a*BBU_STRIDE +: 16]);
		end
		bbu_rec_ok = ok;
	endfunction

endpackage

// *** src/bbu_teach_scan.sv ***
`timescale 1ns/1ps
module bbu_teach_scan
	import bbu_pkg::*;
#(
	parameter int N_BEAMS = BBU_BEAMS
)
(
	input  wire logic               i_core_clk,
	input  wire logic               i_rst,
	input  wire logic               i_start,
	input  wire logic [N_BEAMS-1:0] i_beams,
	input  wire logic [2:0]         i_max_areas,
	output logic                    o_done,
	output logic [2:0]              o_area_cnt,
	output bbu_word_arr_t           o_first,
	output bbu_word_arr_t           o_last
);

	localparam int IW = $clog2(N_BEAMS);

	typedef enum logic {BBU_SC_IDLE, BBU_SC_RUN} bbu_scan_st_t;

	bbu_scan_st_t       state_q, state_d;
	logic [IW-1:0]      idx_q, idx_d;
	logic [N_BEAMS-1:0] snap_q, snap_d;
	logic               in_run_q, in_run_d;
	logic [15:0]        run_first_q, run_first_d;
	logic [2:0]         cnt_q, cnt_d;
	logic [2:0]         max_q, max_d;
	bbu_word_arr_t      first_q, first_d;
	bbu_word_arr_t      last_q, last_d;
	logic               done_q, done_d;
	logic [15:0]        bn;
	logic               hit;
	logic               close;
	logic [15:0]        close_first;
	logic [15:0]        close_last;

	////////////////////////////////////////////////////////////////////////

	// Walks the snapshot one beam a cycle and records interrupted runs
	always_comb
	begin
		state_d     = state_q;
		idx_d       = idx_q;
		snap_d      = snap_q;
		in_run_d    = in_run_q;
		run_first_d = run_first_q;
		cnt_d       = cnt_q;
		max_d       = max_q;
		first_d     = first_q;
		last_d      = last_q;
		done_d      = 1'b0;
		bn          = 16'(idx_q) + 16'h0001;
		hit         = snap_q[idx_q];
		close       = 1'b0;
		close_first = run_first_q;
		close_last  = bn - 16'h0001;
		case (state_q)
			BBU_SC_IDLE:
			begin
				if (i_start)
				begin
					snap_d   = i_beams;
					idx_d    = '0;
					in_run_d = 1'b0;
					cnt_d    = 3'h0;
					max_d    = i_max_areas;
					for (int a = 0; a < BBU_AREAS; a++)
					begin
						first_d[a] = BBU_BEAM_RST;
						last_d[a]  = BBU_BEAM_RST;
					end
					state_d = BBU_SC_RUN;
				end
			end
			BBU_SC_RUN:
			begin
				if (hit && !in_run_q)
				begin
					in_run_d    = 1'b1;
					run_first_d = bn;
				end
				if (!hit && in_run_q)
				begin
					in_run_d = 1'b0;
					close    = 1'b1;
				end
				if (idx_q == IW'(N_BEAMS - 1))
				begin
					if (hit)
					begin
						close       = 1'b1;
						close_first = in_run_q ? run_first_q : bn;
						close_last  = bn;
					end
					state_d = BBU_SC_IDLE;
					done_d  = 1'b1;
				end
				else
					idx_d = idx_q + IW'(1);
				if (close && (cnt_q < max_q) && (cnt_q < 3'(BBU_AREAS)))
				begin
					first_d[cnt_q[1:0]] = close_first;
					last_d[cnt_q[1:0]]  = close_last;
					cnt_d               = cnt_q + 3'h1;
				end
			end
			default:
				state_d = BBU_SC_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			state_q     <= BBU_SC_IDLE;
			idx_q       <= '0;
			snap_q      <= '0;
			in_run_q    <= 1'b0;
			run_first_q <= BBU_BEAM_RST;
			cnt_q       <= 3'h0;
			max_q       <= 3'h0;
			first_q     <= {BBU_AREAS{BBU_BEAM_RST}};
			last_q      <= {BBU_AREAS{BBU_BEAM_RST}};
			done_q      <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			idx_q       <= idx_d;
			snap_q      <= snap_d;
			in_run_q    <= in_run_d;
			run_first_q <= run_first_d;
			cnt_q       <= cnt_d;
			max_q       <= max_d;
			first_q     <= first_d;
			last_q      <= last_d;
			done_q      <= done_d;
		end
	end

	assign o_done     = done_q;
	assign o_area_cnt = cnt_q;
	assign o_first    = first_q;
	assign o_last     = last_q;

	a_scan_cnt_cap: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_q == BBU_SC_RUN) |-> (cnt_q <= max_q))
		else $error("auto teach exceeded permitted area count");

endmodule // bbu_teach_scan

// *** bench/bbu_master_model.sv ***
`timescale 1ns/1ps
module bbu_master_model
	import bbu_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_par_ack,
	input  wire logic                 i_par_err,
	input  wire logic [BBU_REC_W-1:0] i_par_rdata,
	output logic                      o_par_wr,
	output logic                      o_par_rd,
	output logic [15:0]               o_par_index,
	output logic [7:0]                o_par_subindex,
	output logic [BBU_REC_W-1:0]      o_par_wdata
);
	initial
	begin
		o_par_wr       = 1'b0;
		o_par_rd       = 1'b0;
		o_par_index    = 16'h0000;
		o_par_subindex = 8'h00;
		o_par_wdata    = '0;
	end

	////////////////////////////////////////////////////////////////
	// One request pulse, then the answer one cycle later
	task automatic xfer(input logic w, input logic [15:0] x,
		input logic [7:0] s, input logic [BBU_REC_W-1:0] d,
		output logic e, output logic [BBU_REC_W-1:0] r, output logic ok);
		ok = 1'b0;
		e  = 1'b0;
		r  = '0;
		@(posedge i_core_clk);
		o_par_wr       <= w;
		o_par_rd       <= !w;
		o_par_index    <= x;
		o_par_subindex <= s;
		o_par_wdata    <= d;
		@(posedge i_core_clk);
		o_par_wr       <= 1'b0;
		o_par_rd       <= 1'b0;
		o_par_index    <= ~x;
		o_par_subindex <= ~s;
		o_par_wdata    <= ~d;
		for (int n = 0; n < 4 && !ok; n++)
		begin
			#1;
			if (i_par_ack === 1'b1 || i_par_err === 1'b1)
			begin
				ok = 1'b1;
				e  = i_par_err;
				r  = i_par_rdata;
			end
			else
				@(posedge i_core_clk);
		end
	endtask
endmodule // bbu_master_model

// *** bench/bbu_top_tb.sv ***
`timescale 1ns/1ps
module bbu_top_tb
	import bbu_pkg::*;
;
	localparam int          NB  = 16;
	localparam logic [15:0] IDX = BBU_REC_INDEX;
	typedef struct packed {
		logic [1:0]    a;
		logic [15:0]   s, f, l;
		logic [NB-1:0] b, e;
	} bbu_row_t;

	logic                 core_clk, rst, par_wr, par_rd, par_ack, par_err;
	logic                 teach_panel, teach_cmd, teach_busy, teach_done;
	logic [NB-1:0]        beams, beams_out;
	logic [15:0]          par_index;
	logic [7:0]           par_subindex;
	logic [BBU_REC_W-1:0] par_wdata, par_rdata, rd, g;
	logic [BBU_REC_W-1:0] bad [5];
	logic                 err, ok;
	int                   miscompares, tests_run, n;

	bbu_row_t rows [9] = '{
		'{2'd0, BBU_SEL_OFF, 16'h3, 16'h6, 16'h00f0, 16'h00f0},
		'{2'd1, BBU_SEL_ZERO, 16'h3, 16'h6, 16'h00ff, 16'h00c3},
		'{2'd2, BBU_SEL_ONE, 16'h3, 16'h6, 16'h0000, 16'h003c},
		'{2'd0, BBU_SEL_LOWER, 16'h3, 16'h6, 16'h0002, 16'h003e},
		'{2'd0, BBU_SEL_HIGHER, 16'h3, 16'h6, 16'h0040, 16'h007c},
		'{2'd1, BBU_SEL_LOWER, 16'h1, 16'h4, 16'h000f, 16'h0000},
		'{2'd2, BBU_SEL_HIGHER, 16'hd, 16'h10, 16'hf000, 16'h0000},
		'{2'd3, BBU_SEL_ONE, 16'h6, 16'h3, 16'h0000, 16'h0000},
		'{2'd0, BBU_SEL_ONE, 16'h1, 16'h10, 16'h0000, 16'hffff}
	};

	bbu_top #(.N_BEAMS(NB)) i_bbu_top (
		.i_core_clk(core_clk), .i_rst(rst), .i_beams(beams),
		.i_par_wr(par_wr), .i_par_rd(par_rd), .i_par_index(par_index),
		.i_par_subindex(par_subindex), .i_par_wdata(par_wdata),
		.i_teach_panel(teach_panel), .i_teach_cmd(teach_cmd),
		.o_beams(beams_out), .o_par_rdata(par_rdata), .o_par_ack(par_ack),
		.o_par_err(par_err), .o_teach_busy(teach_busy),
		.o_teach_done(teach_done));

	bbu_master_model i_bbu_master_model (
		.i_core_clk(core_clk), .i_par_ack(par_ack), .i_par_err(par_err),
		.i_par_rdata(par_rdata), .o_par_wr(par_wr), .o_par_rd(par_rd),
		.o_par_index(par_index), .o_par_subindex(par_subindex),
		.o_par_wdata(par_wdata));

	////////////////////////////////////////////////////////////////
	function automatic logic [BBU_REC_W-1:0] put(
		input logic [BBU_REC_W-1:0] r, input int a,
		input logic [15:0] s, f, l);
		r[BBU_OFS_SEL0 - a*BBU_STRIDE +: 16]   = s;
		r[BBU_OFS_FIRST0 - a*BBU_STRIDE +: 16] = f;
		r[BBU_OFS_LAST0 - a*BBU_STRIDE +: 16]  = l;
		return r;
	endfunction

	function automatic logic [BBU_REC_W-1:0] dflt(input logic [7:0] c, au);
		logic [BBU_REC_W-1:0] r;
		r = '0;
		for (int k = 0; k < 4; k++)
			r = put(r, k, 16'h0, 16'h1, 16'h1);
		r[BBU_OFS_CNT +: 8]  = c;
		r[BBU_OFS_AUTO +: 8] = au;
		return r;
	endfunction

	task automatic end_sim();
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [BBU_REC_W-1:0] x, y);
		tests_run++;
		if (y !== x)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, x, y);
		end
	endtask

	task automatic acc(input logic w, input logic [15:0] x,
		input logic [7:0] s, input logic [BBU_REC_W-1:0] d, input logic e);
		i_bbu_master_model.xfer(w, x, s, d, err, rd, ok);
		if (ok !== 1'b1)
		begin
			miscompares++;
			end_sim();
		end
		chk("o_par_err", e, err);
	endtask

	task automatic wr(input logic [BBU_REC_W-1:0] d);
		acc(1'b1, IDX, 8'h00, d, 1'b0);
	endtask

	task automatic rd_chk(input logic [BBU_REC_W-1:0] d);
		acc(1'b0, IDX, 8'h00, '0, 1'b0);
		chk("o_par_rdata", d, rd);
	endtask

	task automatic beam(input logic [NB-1:0] b, x);
		@(posedge core_clk);
		beams <= b;
		@(posedge core_clk);
		#1;
		chk("o_beams", x, beams_out);
	endtask

	task automatic teach(input logic p);
		@(posedge core_clk);
		teach_panel <= p;
		teach_cmd   <= !p;
		@(posedge core_clk);
		teach_panel <= 1'b0;
		teach_cmd   <= 1'b0;
		#1;
		chk("o_teach_busy", 1'b1, teach_busy);
	endtask

	task automatic wait_done();
		n = 0;
		while (teach_done !== 1'b1)
		begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > 100)
			begin
				miscompares++;
				end_sim();
			end
		end
		chk("o_teach_busy", 1'b0, teach_busy);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	initial
	begin
		rst = 1'b1;
		beams = '0;
		teach_panel = 1'b0;
		teach_cmd = 1'b0;
		miscompares = 0;
		tests_run = 0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			wr(put(dflt(8'h0, 8'h0), rows[i].a, rows[i].s, rows[i].f,
				rows[i].l));
			beam(rows[i].b, rows[i].e);
		end
		// Lowest area wins where two overlap
		wr(put(put(dflt(8'h0, 8'h0), 0, BBU_SEL_ONE, 16'h1, 16'h8),
			1, BBU_SEL_ZERO, 16'h5, 16'hc));
		beam(16'h0000, 16'h00ff);
		// Upper range limit accepted, then refusals change nothing
		g = put(dflt(8'h4, 8'h0), 3, BBU_SEL_ONE, 16'h06ee, 16'h06ee);
		wr(g);
		rd_chk(g);
		g = put(dflt(8'h0, 8'h0), 2, BBU_SEL_ONE, 16'h3, 16'h6);
		wr(g);
		bad[0] = put(g, 1, 16'h0005, 16'h1, 16'h1);
		bad[1] = put(g, 0, BBU_SEL_ONE, 16'h0, 16'h1);
		bad[2] = put(g, 3, BBU_SEL_ONE, 16'h1, 16'h06ef);
		bad[3] = dflt(8'h5, 8'h0);
		bad[4] = dflt(8'h0, 8'h2);
		foreach (bad[i])
			acc(1'b1, IDX, 8'h00, bad[i], 1'b1);
		acc(1'b1, IDX + 16'h1, 8'h00, g, 1'b1);
		acc(1'b1, IDX, 8'h01, dflt(8'h0, 8'h0), 1'b1);
		acc(1'b0, IDX, 8'h03, '0, 1'b1);
		rd_chk(g);
		beam(16'h0000, 16'h003c);
		// Manual teach keeps blanking; write during teach refused
		teach(1'b0);
		acc(1'b1, IDX, 8'h00, dflt(8'h0, 8'h0), 1'b1);
		wait_done();
		beam(16'h0000, 16'h003c);
		// Auto teach limited to two areas, then teach duration checked
		wr(dflt(8'h2, 8'h1));
		@(posedge core_clk);
		beams <= 16'h0626;
		teach(1'b1);
		wait_done();
		chk("teach_cycles", NB + 2, n);
		rd_chk(put(put(dflt(8'h2, 8'h1), 0, BBU_SEL_ZERO, 16'h2, 16'h3),
			1, BBU_SEL_ZERO, 16'h6, 16'h6));
		beam(16'hffff, 16'hffd9);
		// Auto teach with count zero creates no area
		wr(dflt(8'h0, 8'h1));
		teach(1'b0);
		wait_done();
		rd_chk(dflt(8'h0, 8'h1));
		beam(16'hffff, 16'hffff);
		wr(dflt(8'h2, 8'h0));
		// Second reset returns defaults
		wr(g);
		@(posedge core_clk);
		rst   <= 1'b1;
		beams <= 16'hffff;
		repeat (2) @(posedge core_clk);
		#1;
		chk("o_beams", '0, beams_out);
		chk("o_par_ack", 1'b0, par_ack);
		@(posedge core_clk);
		rst <= 1'b0;
		rd_chk(dflt(8'h0, 8'h0));
		beam(16'h003c, 16'h003c);
		end_sim();
	end
endmodule // bbu_top_tb
